/* File: hdl/clksw_pkg.sv */
package clksw_pkg;

   // ****************************************
   // register word offsets (byte addresses)
   // ****************************************
   localparam logic [3:0] RUN_CTRL_ADDR = 4'h0;  // oscillator_run_control
   localparam logic [3:0] SYS_SEL_ADDR = 4'h4;   // system_clock_select
   localparam logic [3:0] SUB_SEL_ADDR = 4'h8;   // subclock_source_select
   localparam logic [3:0] PIN_MODE_ADDR = 4'hC;  // clock_pin_mode_control
   localparam logic [4:0] WAIT_SEL_ADDR = 5'h10; // stabilization_time_select
   localparam logic [4:0] CNT_STAT_ADDR = 5'h14; // stabilization_counter_status

   // ****************************************
   // field positions
   // ****************************************
   localparam int FAST_HALT_BIT = 0;    // fast_internal_osc_halt
   localparam int MID_EN_BIT = 1;       // mid_internal_osc_enable
   localparam int SUB_HALT_BIT = 6;     // subclock_osc_halt
   localparam int X1_HALT_BIT = 7;      // x1_osc_halt
   localparam int INT_SEL_BIT = 0;      // internal_osc_select
   localparam int INT_STAT_BIT = 1;     // internal_osc_status
   localparam int MAIN_SEL_BIT = 4;     // main_source_select
   localparam int MAIN_STAT_BIT = 5;    // main_source_status
   localparam int CPU_SEL_BIT = 6;      // cpu_clock_select
   localparam int CPU_STAT_BIT = 7;     // cpu_clock_status
   localparam int SLOW_SEL_BIT = 0;     // slow_internal_osc_select
   localparam int GAIN_BIT = 0;         // resonator_gain_high
   localparam int PIN_MODE_BIT = 6;     // fast_pin_mode_select
   localparam int EXT_SEL_BIT = 7;      // external_input_select

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] RUN_CTRL_RST = 8'hC1;  // x1, sub, fast halted; mid enable clear, so mid stopped too
   localparam logic [7:0] SYS_SEL_RST = 8'h01;   // mid osc as main clock
   localparam logic [7:0] SUB_SEL_RST = 8'h00;
   localparam logic [7:0] PIN_MODE_RST = 8'h00;
   localparam logic [2:0] WAIT_CODE_RST = 3'h7;  // longest wait
   localparam logic [7:0] RW_MASK_RUN = 8'hC3;
   localparam logic [7:0] RW_MASK_PIN = 8'hC1;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_MHZ = 50;
   localparam int SWITCH_SETTLE_NS = 100;  // mux hold per side
   localparam int SWITCH_CYCLES = (SWITCH_SETTLE_NS * CLK_MHZ + 999) / 1000;

   // ****************************************
   // carrier: clock mux state
   // ****************************************
   typedef struct packed {
      logic int_mid;   // 1: middle-speed osc feeds main internal
      logic main_x1;   // 1: x1 source feeds main clock
      logic cpu_sub;   // 1: subsystem clock feeds cpu
   } clksw_mux_s;

   typedef enum logic [1:0] {
      SW_IDLE = 2'b00,
      SW_OFF_OLD = 2'b01,
      SW_ON_NEW = 2'b11
   } clksw_state_e;

endpackage : clksw_pkg

/* File: hdl/clksw_top.sv */
module clksw_top #(
   parameter int MAX_WAIT_CODE = 7,         // highest legal wait code
   parameter int BASE_WAIT_CYCLES = 256     // x1 cycles for code 0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // avalon-mm slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // oscillator run controls
   output logic fast_osc_run,
   output logic mid_osc_run,
   output logic slow_osc_run,
   output logic x1_osc_run,
   output logic x1_ext_input,
   output logic x1_gain_high,
   // main_resonator_pins oscillation tick, from outside domain
   input wire logic x1_tick,
   // glitch-free mux selects
   output logic mux_int_mid,
   output logic mux_main_x1,
   output logic mux_cpu_sub
);

   // ****************************************
   // parameter checks
   // ****************************************
   // wait code is three bits wide; the longest count must fit the
   // twenty-bit tick counter, so base << 7 stays below its ceiling
   initial begin
      if (MAX_WAIT_CODE > 7 || MAX_WAIT_CODE < 0 ||
            BASE_WAIT_CYCLES < 1 || BASE_WAIT_CYCLES > 8191)
         $error("clksw_top: unsupported parameters");
   end

   // ****************************************
   // registers
   // ****************************************
   logic [7:0] run_ctrl;       // oscillator_run_control
   logic [7:0] sub_sel;        // subclock_source_select
   logic [7:0] pin_mode;       // clock_pin_mode_control
   logic [2:0] wait_code;      // stabilization_time_select
   clksw_pkg::clksw_mux_s req; // requested selects
   clksw_pkg::clksw_mux_s cur; // applied mux state
   clksw_pkg::clksw_state_e sw_state;
   clksw_pkg::clksw_state_e next_sw_state;
   logic [7:0] settle_cnt;     // per-side hold counter
   logic [7:0] cnt_stat;       // stabilization_counter_status
   logic [19:0] x1_count;      // x1 ticks since start
   logic [2:0] tick_sync;      // three-stage sync
   logic ack;                  // one-cycle bus answer

   // ****************************************
   // bus decode
   // ****************************************
   // a write lands at the answering edge, where waitrequest is low
   wire wr_en = avs_write && avs_byteenable[0] && ack;
   wire hit_run = avs_address == 5'(clksw_pkg::RUN_CTRL_ADDR);
   wire hit_sys = avs_address == 5'(clksw_pkg::SYS_SEL_ADDR);
   wire hit_sub = avs_address == 5'(clksw_pkg::SUB_SEL_ADDR);
   wire hit_pin = avs_address == 5'(clksw_pkg::PIN_MODE_ADDR);
   wire hit_wait = avs_address == clksw_pkg::WAIT_SEL_ADDR;
   wire hit_cnt = avs_address == clksw_pkg::CNT_STAT_ADDR;
   wire [7:0] wd = avs_writedata[7:0];
   // system_clock_select readback: status bits come from applied mux
   wire [7:0] sys_view = {cur.cpu_sub, req.cpu_sub, cur.main_x1,
      req.main_x1, 2'b00, cur.int_mid, req.int_mid};
   wire [7:0] rd_mux = hit_run ? run_ctrl :
      hit_sys ? sys_view :
      hit_sub ? sub_sel :
      hit_pin ? pin_mode :
      hit_wait ? {5'h00, wait_code} :
      hit_cnt ? cnt_stat : 8'h00;
   // one wait state on every access
   assign avs_waitrequest = (avs_read || avs_write) && !ack;

   // bus answer and read data
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else begin
         ack <= (avs_read || avs_write) && !ack;
         if (avs_read && !ack)
            avs_readdata <= {24'h000000, rd_mux};
      end
   end

   // ****************************************
   // register writes
   // ****************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         run_ctrl <= clksw_pkg::RUN_CTRL_RST;
         sub_sel <= clksw_pkg::SUB_SEL_RST;
         pin_mode <= clksw_pkg::PIN_MODE_RST;
         wait_code <= clksw_pkg::WAIT_CODE_RST;
         req <= clksw_pkg::clksw_mux_s'(3'b100);
      end else if (wr_en) begin
         if (hit_run)
            run_ctrl <= wd & clksw_pkg::RW_MASK_RUN;
         if (hit_sub)
            sub_sel <= {7'h00, wd[clksw_pkg::SLOW_SEL_BIT]};
         if (hit_pin)
            pin_mode <= wd & clksw_pkg::RW_MASK_PIN;
         if (hit_wait)
            wait_code <= wd[2:0];
         if (hit_sys) begin
            req.int_mid <= wd[clksw_pkg::INT_SEL_BIT];
            req.main_x1 <= wd[clksw_pkg::MAIN_SEL_BIT];
            req.cpu_sub <= wd[clksw_pkg::CPU_SEL_BIT];
         end
      end
   end

   // ****************************************
   // oscillator run outputs
   // ****************************************
   assign fast_osc_run = !run_ctrl[clksw_pkg::FAST_HALT_BIT];
   assign mid_osc_run = run_ctrl[clksw_pkg::MID_EN_BIT];
   assign slow_osc_run = sub_sel[clksw_pkg::SLOW_SEL_BIT];
   // x1 runs only with pin mode set and halt cleared
   assign x1_osc_run = !run_ctrl[clksw_pkg::X1_HALT_BIT] &&
      pin_mode[clksw_pkg::PIN_MODE_BIT];
   assign x1_ext_input = pin_mode[clksw_pkg::PIN_MODE_BIT] &&
      pin_mode[clksw_pkg::EXT_SEL_BIT];
   assign x1_gain_high = pin_mode[clksw_pkg::GAIN_BIT];

   // ****************************************
   // x1 tick sync and stabilization counter
   // ****************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         tick_sync <= 3'b000;
      else
         tick_sync <= {tick_sync[1:0], x1_tick};
   end
   // a tick counts once stages two and three agree on a rise
   logic tick_seen;
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         tick_seen <= 1'b0;
      else if (tick_sync[1] == tick_sync[2])
         tick_seen <= tick_sync[2];
   end
   wire tick_ev = (tick_sync[1] == tick_sync[2]) && tick_sync[2] &&
      !tick_seen;

   // counter fills from the msb as elapsed time passes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         x1_count <= 20'h00000;
         cnt_stat <= 8'h00;
      end else if (!x1_osc_run) begin
         x1_count <= 20'h00000;
         cnt_stat <= 8'h00;
      end else begin
         // saturate rather than wrap, so a long run never clears bits
         if (tick_ev && x1_count != 20'hFFFFF)
            x1_count <= x1_count + 20'h00001;
         for (int i = 0; i < 8; i++) begin
            if (x1_count >= 20'(BASE_WAIT_CYCLES << i))
               cnt_stat[7 - i] <= 1'b1;
         end
      end
   end
   // selected wait done: code n means msb..(7-n) filled
   wire [7:0] wait_goal = 8'(8'hFF << (3'd7 - wait_code));
   wire x1_stable = x1_ext_input ||
      ((cnt_stat & wait_goal) == wait_goal);

   // ****************************************
   // glitch-free switch sequencer
   // ****************************************
   wire change = req != cur;
   always_comb begin
      next_sw_state = sw_state;
      unique case (sw_state)
         // a new request opens the gap
         clksw_pkg::SW_IDLE:
            if (change)
               next_sw_state = clksw_pkg::SW_OFF_OLD;
         // old source held off for the settle time
         clksw_pkg::SW_OFF_OLD:
            if (settle_cnt == 8'(clksw_pkg::SWITCH_CYCLES))
               next_sw_state = clksw_pkg::SW_ON_NEW;
         // old source back on for the settle time; status and mux move at its end
         clksw_pkg::SW_ON_NEW:
            if (settle_cnt == 8'(clksw_pkg::SWITCH_CYCLES))
               next_sw_state = clksw_pkg::SW_IDLE;
         // unused code falls back to idle
         default:
            next_sw_state = clksw_pkg::SW_IDLE;
      endcase
   end

   // hold old source off, then back on, then mux and status move to the request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sw_state <= clksw_pkg::SW_IDLE;
         settle_cnt <= 8'h00;
         cur <= clksw_pkg::clksw_mux_s'(3'b100);
      end else begin
         sw_state <= next_sw_state;
         settle_cnt <= next_sw_state != sw_state ? 8'h00 :
            settle_cnt + 8'h01;
         if (sw_state == clksw_pkg::SW_ON_NEW &&
               next_sw_state == clksw_pkg::SW_IDLE) begin
            cur.int_mid <= req.int_mid;
            cur.cpu_sub <= req.cpu_sub;
            if (x1_stable || !req.main_x1)
               cur.main_x1 <= req.main_x1;
         end
      end
   end

   // mux gated off while the switch is between sources
   wire gap = sw_state == clksw_pkg::SW_OFF_OLD;
   assign mux_int_mid = cur.int_mid && !gap;
   assign mux_main_x1 = cur.main_x1 && !gap;
   assign mux_cpu_sub = cur.cpu_sub && !gap;

   // ****************************************
   // assertions
   // ****************************************

   // fast osc follows its halt bit after each run write
   AST_FAST_RUN: assert property (@(posedge clk) disable iff (rst)
      wr_en && hit_run |=>
      fast_osc_run == !$past(wd[clksw_pkg::FAST_HALT_BIT]))
      else $error("fast run wrong");

   // middle-speed osc only starts by a write
   AST_MID_RUN: assert property (@(posedge clk) disable iff (rst)
      $rose(mid_osc_run) |-> $past(wr_en && hit_run))
      else $error("mid run without write");

   // middle-speed osc follows its enable bit after each run write
   AST_MID_OFF: assert property (@(posedge clk) disable iff (rst)
      wr_en && hit_run |=>
      mid_osc_run == $past(wd[clksw_pkg::MID_EN_BIT]))
      else $error("mid run not following enable");

   // slow osc only starts by a write
   AST_SLOW_RUN: assert property (@(posedge clk) disable iff (rst)
      $rose(slow_osc_run) |-> $past(wr_en && hit_sub))
      else $error("slow run without write");

   // slow osc follows its select bit after each write
   AST_SLOW_SEL: assert property (@(posedge clk) disable iff (rst)
      wr_en && hit_sub |=>
      slow_osc_run == $past(wd[clksw_pkg::SLOW_SEL_BIT]))
      else $error("slow run not following select");

   // external input needs both pin mode and external select
   AST_EXT: assert property (@(posedge clk) disable iff (rst)
      wr_en && hit_pin |=>
      x1_ext_input == $past(wd[clksw_pkg::EXT_SEL_BIT] &&
      wd[clksw_pkg::PIN_MODE_BIT]))
      else $error("external input select wrong");

   // x1 runs once its halt bit is cleared, pin mode given
   AST_X1_RUN: assert property (@(posedge clk) disable iff (rst)
      wr_en && hit_run |=>
      x1_osc_run == (!$past(wd[clksw_pkg::X1_HALT_BIT]) &&
      pin_mode[clksw_pkg::PIN_MODE_BIT]))
      else $error("x1 run not following halt bit");

   // status bits fill from the msb downward
   AST_FILL: assert property (@(posedge clk) disable iff (rst)
      cnt_stat[6] |-> cnt_stat[7])
      else $error("counter not msb first");

   // a stopped x1 leaves the counter status empty
   AST_CNT_CLR: assert property (@(posedge clk) disable iff (rst)
      !x1_osc_run |=> cnt_stat == 8'h00)
      else $error("counter status not cleared");

   // any resonator wait goal needs at least the first bit
   AST_STABLE: assert property (@(posedge clk) disable iff (rst)
      x1_stable && !x1_ext_input |-> cnt_stat[7])
      else $error("x1 stable with empty counter");

   // wait code keeps the written three bits
   AST_WAIT_CODE: assert property (@(posedge clk) disable iff (rst)
      wr_en && hit_wait |=> wait_code == $past(wd[2:0]))
      else $error("wait code lost");

   // cpu status rises only at the end of a switch
   AST_CPU_STAT: assert property (@(posedge clk) disable iff (rst)
      $rose(cur.cpu_sub) |-> $past(sw_state == clksw_pkg::SW_ON_NEW))
      else $error("cpu status early");

   // cpu status falls only at the end of a switch
   AST_CPU_DROP: assert property (@(posedge clk) disable iff (rst)
      $fell(cur.cpu_sub) |-> $past(sw_state == clksw_pkg::SW_ON_NEW))
      else $error("cpu status dropped early");

   // internal status only moves to the requested source
   AST_INT_STAT: assert property (@(posedge clk) disable iff (rst)
      $changed(cur.int_mid) |-> cur.int_mid == req.int_mid)
      else $error("internal status wrong");

   // main status reaches x1 only once x1 is stable
   AST_MAIN_STAT: assert property (@(posedge clk) disable iff (rst)
      $rose(cur.main_x1) |-> $past(x1_stable))
      else $error("main status before stable");

   // select bits take the written values
   AST_SEL: assert property (@(posedge clk) disable iff (rst)
      wr_en && hit_sys |=>
      req.cpu_sub == $past(wd[clksw_pkg::CPU_SEL_BIT]))
      else $error("cpu select lost");
   AST_INTSEL: assert property (@(posedge clk) disable iff (rst)
      wr_en && hit_sys |=>
      req.int_mid == $past(wd[clksw_pkg::INT_SEL_BIT]))
      else $error("internal select lost");
   AST_MAINSEL: assert property (@(posedge clk) disable iff (rst)
      wr_en && hit_sys |=>
      req.main_x1 == $past(wd[clksw_pkg::MAIN_SEL_BIT]))
      else $error("main select lost");

   // every mux output drops as a switch begins
   AST_GAP: assert property (@(posedge clk) disable iff (rst)
      sw_state == clksw_pkg::SW_IDLE && change |=>
      !mux_int_mid && !mux_main_x1 && !mux_cpu_sub)
      else $error("no gap in switch");

   // gap lasts settle count plus one cycles, six at 50 MHz
   AST_OFF_LEN: assert property (@(posedge clk) disable iff (rst)
      sw_state == clksw_pkg::SW_IDLE && change |=>
      gap [*6] ##1 !gap)
      else $error("switch gap length wrong");

   // status stays put while the old source is held off
   AST_STAT_HOLD: assert property (@(posedge clk) disable iff (rst)
      sw_state == clksw_pkg::SW_OFF_OLD |=> $stable(cur))
      else $error("status moved inside the gap");

endmodule : clksw_top

/* File: sim/clksw_x1_model.sv */
// ****************************************
// x1 resonator stand-in
// ****************************************
module clksw_x1_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // run request from the block
   input wire logic run,
   // oscillation output
   output logic tick
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] div; // slows ticks to clk/8
   // oscillates only while run, else stands still low
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div <= 2'h0;
         tick <= 1'b0;
      end else if (run) begin
         div <= div + 2'h1;
         if (div == 2'h1) begin
            tick <= ~tick;
         end
      end else begin
         tick <= 1'b0;
      end
   end
endmodule : clksw_x1_model

/* File: sim/tb.sv */
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // signals
   // ****************************************
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic fast_osc_run, mid_osc_run, slow_osc_run;
   logic x1_osc_run, x1_ext_input, x1_gain_high, x1_tick;
   logic mux_int_mid, mux_main_x1, mux_cpu_sub;
   int bad_count = 0;
   int samples_checked = 0;
   logic [7:0] v, n; // read value, helper
   logic [3:0] be = 4'hF; // byte lanes for the next request
   // software stabilisation waits, in clock cycles
   localparam int FAST_WAIT_CYC = 65 * clksw_pkg::CLK_MHZ; // 65 us
   localparam int SLOW_WAIT_CYC = 210 * clksw_pkg::CLK_MHZ; // 210 us
   always #10 clk = ~clk; // 50 MHz
   clksw_top #(.BASE_WAIT_CYCLES(2)) i_dut (.clk(clk), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .fast_osc_run(fast_osc_run),
      .mid_osc_run(mid_osc_run), .slow_osc_run(slow_osc_run),
      .x1_osc_run(x1_osc_run), .x1_ext_input(x1_ext_input),
      .x1_gain_high(x1_gain_high), .x1_tick(x1_tick),
      .mux_int_mid(mux_int_mid), .mux_main_x1(mux_main_x1),
      .mux_cpu_sub(mux_cpu_sub));
   clksw_x1_model i_x1 (.clk(clk), .rst(rst), .run(x1_osc_run),
      .tick(x1_tick));
   // ****************************************
   // tasks
   // ****************************************
   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : final_report
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         $display("Error %0t: got %h want %h", $time, seen, exp);
         bad_count++;
      end
   endtask : chk
   // one avalon cycle, held until waitrequest sampled low at a rise
   task automatic bus(input logic [4:0] a, input logic wr,
                      input logic [7:0] d, output logic [7:0] q);
      int i;
      @(posedge clk);
      avs_address <= a;
      avs_read <= ~wr;
      avs_write <= wr;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= be;
      i = 0;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) begin
         i++;
         if (i > 50) begin
            bad_count++;
            final_report();
         end
         @(posedge clk);
      end
      // answering edge: take read data, then release
      q = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // outputs launched at the answering edge settle by the fall
      @(negedge clk);
   endtask : bus
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(a, 1'b1, d, q);
   endtask : wr
   task automatic rd(input logic [4:0] a);
      bus(a, 1'b0, 8'h00, v);
   endtask : rd
   // poll select register until one status bit reaches val
   task automatic wait_stat(input int b, input logic val);
      int i;
      i = 0;
      rd({1'b0, clksw_pkg::SYS_SEL_ADDR});
      while (v[b] !== val && i < 60) begin
         i++;
         rd({1'b0, clksw_pkg::SYS_SEL_ADDR});
      end
      chk({7'h0, v[b]}, {7'h0, val});
   endtask : wait_stat
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      rd({1'b0, clksw_pkg::RUN_CTRL_ADDR});
      chk(v, clksw_pkg::RUN_CTRL_RST);
      rd({1'b0, clksw_pkg::SYS_SEL_ADDR});
      chk(v & 8'h51, clksw_pkg::SYS_SEL_RST);
      rd(clksw_pkg::WAIT_SEL_ADDR);
      chk(v, {5'h0, clksw_pkg::WAIT_CODE_RST});
      rd(clksw_pkg::CNT_STAT_ADDR);
      chk(v, 8'h00);
      chk({7'h0, fast_osc_run}, 8'h00);
   endtask : t_reset
   task automatic t_mid_to_fast;
      wr({1'b0, clksw_pkg::RUN_CTRL_ADDR}, 8'hC2);
      chk({7'h0, fast_osc_run}, 8'h01);
      chk({7'h0, mid_osc_run}, 8'h01);
      repeat (FAST_WAIT_CYC) @(posedge clk);
      wr({1'b0, clksw_pkg::SYS_SEL_ADDR}, 8'h00);
      rd({1'b0, clksw_pkg::SYS_SEL_ADDR});
      chk({7'h0, v[1]}, 8'h01);
      wait_stat(clksw_pkg::INT_STAT_BIT, 1'b0);
      chk({7'h0, mux_int_mid}, 8'h00);
      wr({1'b0, clksw_pkg::RUN_CTRL_ADDR}, 8'hC0);
      chk({7'h0, mid_osc_run}, 8'h00);
   endtask : t_mid_to_fast
   task automatic t_slow;
      wr({1'b0, clksw_pkg::SUB_SEL_ADDR}, 8'h01);
      chk({7'h0, slow_osc_run}, 8'h01);
      repeat (SLOW_WAIT_CYC) @(posedge clk);
      wr({1'b0, clksw_pkg::SYS_SEL_ADDR}, 8'h40);
      rd({1'b0, clksw_pkg::SYS_SEL_ADDR});
      chk({7'h0, v[7]}, 8'h00);
      wait_stat(clksw_pkg::CPU_STAT_BIT, 1'b1);
      chk({7'h0, mux_cpu_sub}, 8'h01);
      wr({1'b0, clksw_pkg::SYS_SEL_ADDR}, 8'h00);
      wait_stat(clksw_pkg::CPU_STAT_BIT, 1'b0);
   endtask : t_slow
   task automatic t_x1;
      int i;
      wr({1'b0, clksw_pkg::PIN_MODE_ADDR}, 8'h41);
      chk({7'h0, x1_ext_input}, 8'h00);
      chk({7'h0, x1_gain_high}, 8'h01);
      wr(clksw_pkg::WAIT_SEL_ADDR, 8'hFA);
      rd(clksw_pkg::WAIT_SEL_ADDR);
      chk(v, 8'h02);
      wr({1'b0, clksw_pkg::RUN_CTRL_ADDR}, 8'h40);
      chk({7'h0, x1_osc_run}, 8'h01);
      i = 0;
      v = 8'h00;
      while ((v & 8'hE0) !== 8'hE0 && i < 200) begin
         i++;
         rd(clksw_pkg::CNT_STAT_ADDR);
         n = ~v;
         chk(n & (n + 8'h01), 8'h00);
      end
      chk(v & 8'hE0, 8'hE0);
      wr({1'b0, clksw_pkg::SYS_SEL_ADDR}, 8'h10);
      wait_stat(clksw_pkg::MAIN_STAT_BIT, 1'b1);
      chk({7'h0, mux_main_x1}, 8'h01);
      wr({1'b0, clksw_pkg::PIN_MODE_ADDR}, 8'hC0);
      chk({7'h0, x1_ext_input}, 8'h01);
      wr({1'b0, clksw_pkg::RUN_CTRL_ADDR}, 8'h41);
      chk({7'h0, fast_osc_run}, 8'h00);
   endtask : t_x1
   task automatic t_refused;
      rd(5'h18);
      chk(v, 8'h00);
      be = 4'h0;
      wr({1'b0, clksw_pkg::SUB_SEL_ADDR}, 8'h00);
      be = 4'hF;
      rd({1'b0, clksw_pkg::SUB_SEL_ADDR});
      chk(v, 8'h01);
   endtask : t_refused
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_mid_to_fast();
      t_slow();
      t_x1();
      t_refused();
      final_report();
   end
endmodule : tb
